// >>> hw/hcr_cpu_if_regs.sv
// Processor-side identification, scratch, software reset and DMA registers on APB
//
// Contract
// - Identity register is read-only; high half version, low half part code.
// - Scratch register reads back the last value written to each strobed byte lane.
// - Controller-only reset bit resets registers below 300h; writing zero does nothing.
// - Full reset bit resets all controller and processor interface registers.
// - DMA config bits 31..8 hold a 24-bit byte count for reads and writes.
// - Burst count derives from byte count, the active bus width and the burst size.
// - Burst size field: 00 single, 01 four, 10 eight, 11 sixteen cycles.
// - Direction 0 writes internal RAM, 1 reads; enable starts, clearing terminates.
// - Bus width bit in mode register: 0 sixteen-bit, 1 thirty-two-bit.
`timescale 1ns/1ps
module hcr_cpu_if_regs
    import hcr_pkg::*;
#(
    // Identification values, arbitrary
    parameter logic [15:0] HW_VERSION   = 16'h00A5,
    parameter logic [15:0] PART_CODE    = 16'h5A3C,
    parameter int          PULSE_CYCLES = HCR_RESET_PULSE_CYCLES
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // DMA side
    input  wire logic        dma_beat,
    output logic             dma_active,
    output logic             dma_read_dir,
    output logic [4:0]       dma_burst_beats,
    output logic             dma_done,
    // Mode and reset outputs
    output logic             bus_width_32,
    output logic             controller_only_reset,
    output logic             full_reset
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic        bus32;
        logic [31:0] scratch;
        logic [23:0] dma_len;
        logic [1:0]  burst_size_select;
        logic        dma_en;
        logic        dma_dir;
        logic [31:0] prdata;
        logic        pslverr;
        logic        dma_start;
        logic        hc_req;
        logic        all_req;
    } hcr_regs_t;

    hcr_regs_t r;
    hcr_regs_t next_r;

    logic        setup;
    logic        wr_take;
    logic        addr_hit;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic [31:0] cfg_word;
    logic [31:0] cfg_new;
    logic [31:0] mode_new;
    logic [31:0] srst_new;
    logic        eng_active;
    logic        eng_done;
    logic [23:0] eng_remaining;
    logic [23:0] eng_bursts;
    logic [4:0]  eng_beats;
    logic        sw_all_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Byte lane mask

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = 8'hFF;
            end
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        return (old_v & ~m) | (new_v & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode and read mux

    assign setup   = psel && !penable;
    assign wr_take = psel && penable && pwrite;
    assign wmask   = lane_mask(pstrb);

    always_comb begin
        addr_hit = 1'b1;
        case (paddr)
            HCR_OFS_MODE,
            HCR_OFS_ID,
            HCR_OFS_SCRATCH,
            HCR_OFS_SWRST,
            HCR_OFS_DMA_CFG,
            HCR_OFS_DMA_STAT,
            HCR_OFS_DMA_BURSTS: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        cfg_word = 32'h00000000;
        cfg_word[HCR_DMA_LEN_LSB +: HCR_DMA_LEN_W] = r.dma_len;
        cfg_word[HCR_DMA_BURST_LSB +: 2]           = r.burst_size_select;
        cfg_word[HCR_DMA_EN_BIT]                   = r.dma_en;
        cfg_word[HCR_DMA_DIR_BIT]                  = r.dma_dir;
    end

    always_comb begin
        rd_word = 32'h00000000;
        case (paddr)
            HCR_OFS_MODE: begin
                rd_word[HCR_MODE_BUS32_BIT] = r.bus32;
            end
            HCR_OFS_ID: begin
                rd_word = {HW_VERSION, PART_CODE};
            end
            HCR_OFS_SCRATCH: begin
                rd_word = r.scratch;
            end
            HCR_OFS_SWRST: begin
                rd_word = 32'h00000000;
            end
            HCR_OFS_DMA_CFG: begin
                rd_word = cfg_word;
            end
            HCR_OFS_DMA_STAT: begin
                rd_word[HCR_STAT_REM_LSB +: HCR_DMA_LEN_W] = eng_remaining;
                rd_word[HCR_STAT_ACT_BIT]                  = eng_active;
            end
            HCR_OFS_DMA_BURSTS: begin
                rd_word[23:0] = eng_bursts;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write values after byte lanes, reserved bits dropped

    always_comb begin
        cfg_new  = merge(cfg_word, pwdata, wmask);
        mode_new = 32'h00000000;
        mode_new[HCR_MODE_BUS32_BIT] = r.bus32;
        mode_new = merge(mode_new, pwdata, wmask);
        srst_new = pwdata & wmask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_r           = r;
        next_r.dma_start = 1'b0;
        next_r.hc_req    = 1'b0;
        next_r.all_req   = 1'b0;

        // Read data and error captured in the setup cycle
        if (setup) begin
            next_r.prdata  = pwrite ? 32'h00000000 : rd_word;
            next_r.pslverr = !addr_hit || (pwrite && (paddr == HCR_OFS_ID ||
                             paddr == HCR_OFS_DMA_STAT || paddr == HCR_OFS_DMA_BURSTS));
        end

        // Completed DMA drops the enable bit
        if (eng_done) begin
            next_r.dma_en = 1'b0;
        end

        if (wr_take) begin
            case (paddr)
                HCR_OFS_MODE: begin
                    next_r.bus32 = mode_new[HCR_MODE_BUS32_BIT];
                end
                HCR_OFS_SCRATCH: begin
                    next_r.scratch = merge(r.scratch, pwdata, wmask);
                end
                HCR_OFS_SWRST: begin
                    next_r.hc_req  = srst_new[HCR_SWRST_HC_BIT];
                    next_r.all_req = srst_new[HCR_SWRST_ALL_BIT];
                end
                HCR_OFS_DMA_CFG: begin
                    // Reserved bits 7..4 are not stored
                    next_r.dma_len           = cfg_new[HCR_DMA_LEN_LSB +: HCR_DMA_LEN_W];
                    next_r.burst_size_select = cfg_new[HCR_DMA_BURST_LSB +: 2];
                    next_r.dma_dir           = cfg_new[HCR_DMA_DIR_BIT];
                    next_r.dma_en            = cfg_new[HCR_DMA_EN_BIT];
                    next_r.dma_start         = cfg_new[HCR_DMA_EN_BIT] && !eng_active;
                end
                default: begin
                    next_r.bus32 = r.bus32;
                end
            endcase
        end

        // Full software reset returns mode, scratch and DMA config to reset values; prdata and pslverr hold
        if (r.all_req) begin
            next_r                   = r;
            next_r.bus32             = HCR_MODE_BUS32_RST;
            next_r.scratch           = HCR_SCRATCH_RST;
            next_r.dma_len           = HCR_DMA_CFG_RST[HCR_DMA_LEN_LSB +: HCR_DMA_LEN_W];
            next_r.burst_size_select = HCR_DMA_CFG_RST[HCR_DMA_BURST_LSB +: 2];
            next_r.dma_en            = HCR_DMA_CFG_RST[HCR_DMA_EN_BIT];
            next_r.dma_dir           = HCR_DMA_CFG_RST[HCR_DMA_DIR_BIT];
            next_r.dma_start         = 1'b0;
            next_r.hc_req            = 1'b0;
            next_r.all_req           = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r                   <= '0;
            r.bus32             <= HCR_MODE_BUS32_RST;
            r.scratch           <= HCR_SCRATCH_RST;
            r.dma_len           <= HCR_DMA_CFG_RST[HCR_DMA_LEN_LSB +: HCR_DMA_LEN_W];
            r.burst_size_select <= HCR_DMA_CFG_RST[HCR_DMA_BURST_LSB +: 2];
            r.dma_en            <= HCR_DMA_CFG_RST[HCR_DMA_EN_BIT];
            r.dma_dir           <= HCR_DMA_CFG_RST[HCR_DMA_DIR_BIT];
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DMA engine

    hcr_dma_engine u_dma (
        .pclk        (pclk),
        .presetn     (presetn),
        .sync_clear  (r.all_req),
        .start       (r.dma_start),
        .enable      (r.dma_en),
        .length      (r.dma_len),
        .bus32       (r.bus32),
        .burst_sel   (r.burst_size_select),
        .beat        (dma_beat),
        .active      (eng_active),
        .done        (eng_done),
        .remaining   (eng_remaining),
        .burst_count (eng_bursts),
        .burst_beats (eng_beats)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Software reset pulses

    hcr_soft_reset #(
        .PULSE_CYCLES (PULSE_CYCLES)
    ) u_srst (
        .pclk      (pclk),
        .presetn   (presetn),
        .hc_req    (r.hc_req),
        .all_req   (r.all_req),
        .hc_reset  (controller_only_reset),
        .all_reset (sw_all_reset)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata          = r.prdata;
    assign pready          = 1'b1;
    assign pslverr         = psel && penable && r.pslverr;
    assign dma_active      = eng_active;
    assign dma_read_dir    = r.dma_dir;
    assign dma_burst_beats = eng_beats;
    assign dma_done        = eng_done;
    assign bus_width_32    = r.bus32;
    assign full_reset      = sw_all_reset;

endmodule

// >>> hw/hcr_dma_engine.sv
// DMA byte counter and burst planner
`timescale 1ns/1ps
module hcr_dma_engine
    import hcr_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        sync_clear,
    // Configuration
    input  wire logic        start,
    input  wire logic        enable,
    input  wire logic [23:0] length,
    input  wire logic        bus32,
    input  wire logic [1:0]  burst_sel,
    // Transfer progress
    input  wire logic        beat,
    output logic             active,
    output logic             done,
    output logic [23:0]      remaining,
    output logic [23:0]      burst_count,
    output logic [4:0]       burst_beats
);

    typedef struct packed {
        hcr_dma_state_t st;
        logic [23:0]    remaining;
        logic [23:0]    bursts;
        logic [4:0]     beats;
        logic           done;
    } hcr_dma_t;

    hcr_dma_t    r;
    hcr_dma_t    next_r;
    logic [23:0] step;
    logic [25:0] beats_total;
    logic [25:0] bursts_total;
    logic [2:0]  bshift;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        step         = bus32 ? 24'h000004 : 24'h000002;
        bshift       = (burst_sel == HCR_BURST_SINGLE) ? 3'h0 :
                       (burst_sel == HCR_BURST_4)      ? 3'h2 :
                       (burst_sel == HCR_BURST_8)      ? 3'h3 : 3'h4;
        beats_total  = bus32 ? (({2'h0, length} + 26'h0000003) >> 2)
                             : (({2'h0, length} + 26'h0000001) >> 1);
        bursts_total = (beats_total + ((26'h0000001 << bshift) - 26'h0000001)) >> bshift;
        next_r       = r;
        next_r.done  = 1'b0;
        case (r.st)
            HCR_DMA_IDLE: begin
                if (start) begin
                    next_r.remaining = length;
                    next_r.bursts    = bursts_total[23:0];
                    next_r.beats     = 5'(5'h01 << bshift);
                    if (length == 24'h000000) begin
                        next_r.done = 1'b1;
                    end else begin
                        next_r.st = HCR_DMA_RUN;
                    end
                end
            end
            HCR_DMA_RUN: begin
                if (!enable) begin
                    next_r.st = HCR_DMA_IDLE;
                end else if (beat) begin
                    if (r.remaining <= step) begin
                        next_r.remaining = 24'h000000;
                        next_r.done      = 1'b1;
                        next_r.st        = HCR_DMA_IDLE;
                    end else begin
                        next_r.remaining = r.remaining - step;
                    end
                end
            end
            default: begin
                next_r.st = HCR_DMA_IDLE;
            end
        endcase
        if (sync_clear) begin
            next_r = '{st: HCR_DMA_IDLE, default: '0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: HCR_DMA_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign active      = (r.st == HCR_DMA_RUN);
    assign done        = r.done;
    assign remaining   = r.remaining;
    assign burst_count = r.bursts;
    assign burst_beats = r.beats;

endmodule

// >>> hw/hcr_soft_reset.sv
// Software reset pulse stretcher for controller-only and full reset
`timescale 1ns/1ps
module hcr_soft_reset
    import hcr_pkg::*;
#(
    parameter int PULSE_CYCLES = HCR_RESET_PULSE_CYCLES
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Requests
    input  wire logic hc_req,
    input  wire logic all_req,
    // Reset outputs
    output logic      hc_reset,
    output logic      all_reset
);

    typedef struct packed {
        logic [7:0] hc_cnt;
        logic [7:0] all_cnt;
        logic       hc_reset;
        logic       all_reset;
    } hcr_srst_t;

    localparam logic [7:0] LOAD = 8'(PULSE_CYCLES);

    hcr_srst_t r;
    hcr_srst_t next_r;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_r = r;
        if (r.hc_cnt != 8'h00) begin
            next_r.hc_cnt = r.hc_cnt - 8'h01;
        end
        if (r.all_cnt != 8'h00) begin
            next_r.all_cnt = r.all_cnt - 8'h01;
        end
        if (hc_req || all_req) begin
            next_r.hc_cnt = LOAD;
        end
        if (all_req) begin
            next_r.all_cnt = LOAD;
        end
        next_r.hc_reset  = (next_r.hc_cnt != 8'h00);
        next_r.all_reset = (next_r.all_cnt != 8'h00);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign hc_reset  = r.hc_reset;
    assign all_reset = r.all_reset;

endmodule

// >>> shared/hcr_pkg.sv
// Constants and types shared by the processor-side configuration registers
package hcr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [11:0] HCR_OFS_MODE       = 12'h300;
    localparam logic [11:0] HCR_OFS_ID         = 12'h304;
    localparam logic [11:0] HCR_OFS_SCRATCH    = 12'h308;
    localparam logic [11:0] HCR_OFS_SWRST      = 12'h30C;
    localparam logic [11:0] HCR_OFS_DMA_CFG    = 12'h330;
    localparam logic [11:0] HCR_OFS_DMA_STAT   = 12'h3F0;
    localparam logic [11:0] HCR_OFS_DMA_BURSTS = 12'h3F4;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and widths
    localparam int          HCR_MODE_BUS32_BIT = 8;
    localparam int          HCR_SWRST_ALL_BIT  = 0;
    localparam int          HCR_SWRST_HC_BIT   = 1;
    localparam int          HCR_DMA_LEN_LSB    = 8;
    localparam int          HCR_DMA_LEN_W      = 24;
    localparam int          HCR_DMA_BURST_LSB  = 2;
    localparam int          HCR_DMA_EN_BIT     = 1;
    localparam int          HCR_DMA_DIR_BIT    = 0;
    localparam int          HCR_STAT_ACT_BIT   = 0;
    localparam int          HCR_STAT_REM_LSB   = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic        HCR_MODE_BUS32_RST = 1'b1;
    localparam logic [31:0] HCR_SCRATCH_RST    = 32'h00000000;
    localparam logic [31:0] HCR_DMA_CFG_RST    = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          HCR_RESET_PULSE_CYCLES = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Burst size encoding
    typedef enum logic [1:0] {
        HCR_BURST_SINGLE = 2'h0,
        HCR_BURST_4      = 2'h1,
        HCR_BURST_8      = 2'h2,
        HCR_BURST_16     = 2'h3
    } hcr_burst_t;

    // DMA engine states
    typedef enum logic [1:0] {
        HCR_DMA_IDLE = 2'b01,
        HCR_DMA_RUN  = 2'b10
    } hcr_dma_state_t;

endpackage

// >>> verif/hcr_cpu_if_regs_chk.sv
// Assertion checker for the processor-side configuration registers
`timescale 1ns/1ps
module hcr_cpu_if_regs_chk
    import hcr_pkg::*;
#(
    parameter logic [15:0] HW_VERSION   = 16'h0000,
    parameter logic [15:0] PART_CODE    = 16'h0000,
    parameter int          PULSE_CYCLES = 4
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // DMA, mode and resets
    input wire logic        dma_beat,
    input wire logic        dma_active,
    input wire logic        dma_read_dir,
    input wire logic [4:0]  dma_burst_beats,
    input wire logic        dma_done,
    input wire logic        bus_width_32,
    input wire logic        controller_only_reset,
    input wire logic        full_reset
);
    logic [7:0] hi_cnt;
    logic       acc;
    assign acc = psel && penable;
    // Length of the current full reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 8'h00;
        end else begin
            hi_cnt <= full_reset ? hi_cnt + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    a_id_value: assert property (acc && !pwrite && paddr == HCR_OFS_ID |->
        prdata == {HW_VERSION, PART_CODE} && !pslverr) else $error("identity read wrong");
    a_id_readonly: assert property (acc && pwrite && paddr == HCR_OFS_ID |-> pslverr)
        else $error("identity write accepted");
    a_scratch_ok: assert property (acc && paddr == HCR_OFS_SCRATCH |-> !pslverr)
        else $error("scratch access refused");
    a_hc_reset_req: assert property (acc && pwrite && paddr == HCR_OFS_SWRST && pstrb[0] && pwdata[1]
        |-> ##[1:3] controller_only_reset) else $error("controller reset missing");
    a_full_with_hc: assert property (full_reset |-> controller_only_reset)
        else $error("full reset without controller reset");
    a_full_width: assert property ($fell(full_reset) |-> hi_cnt == PULSE_CYCLES)
        else $error("full reset pulse length wrong");
    a_full_restores: assert property ($rose(full_reset) |=> bus_width_32 && !dma_active)
        else $error("full reset left state");
    a_burst_size: assert property (dma_active |-> dma_burst_beats inside {5'd1, 5'd4, 5'd8, 5'd16})
        else $error("burst size invalid");
    a_done_pulse: assert property (dma_done |=> !dma_done)
        else $error("done longer than one cycle");
    a_done_stops: assert property (dma_done |-> ##[0:1] !dma_active)
        else $error("active after done");
    c_full: cover property ($rose(full_reset));
    c_done: cover property (dma_done);
    c_err: cover property (acc && pslverr);
endmodule

// >>> verif/hcr_cpu_if_regs_test.sv
// Self-checking testbench for the processor-side configuration registers
`timescale 1ns/1ps
module hcr_cpu_if_regs_test;
    import hcr_pkg::*;
    // Identification values, arbitrary
    localparam logic [15:0] HWV = 16'h0C3E;
    localparam logic [15:0] PCODE = 16'h7B21;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [3:0]  gap = 4'h0;
    logic [31:0] prdata, rd_data;
    logic        pready, pslverr, rd_err, seen;
    logic        dma_beat, dma_active, dma_read_dir, dma_done;
    logic        bus_width_32, controller_only_reset, full_reset;
    logic [4:0]  dma_burst_beats;
    int          miscompares = 0, checks_done = 0, cycles = 0, beats = 0, dones = 0, n;
    hcr_cpu_if_regs #(.HW_VERSION(HWV), .PART_CODE(PCODE), .PULSE_CYCLES(4)) uut (.*);
    hcr_dma_peer peer (.*);
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (dma_beat === 1'b1 && dma_active === 1'b1) beats++;
        if (dma_done === 1'b1) dones++;
        if (cycles == 30000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd_data, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_ident();
        rdc(HCR_OFS_ID, {HWV, PCODE});
        apb(1'b1, HCR_OFS_ID, 32'hFFFF_FFFF);
        check({31'h0, rd_err}, 32'h1);
        rdc(HCR_OFS_ID, {HWV, PCODE});
        rdc(12'h0FC, 32'h0);
        check({31'h0, rd_err}, 32'h1);
        $display("test ident done");
    endtask
    task automatic t_regs();
        logic [31:0] pats [4] = '{32'hFFFF_FFFF, 32'h0000_0001, 32'h8000_0000, 32'hA5C3_3C5A};
        rdc(HCR_OFS_SCRATCH, HCR_SCRATCH_RST);
        rdc(HCR_OFS_MODE, 32'h0000_0100);
        rdc(HCR_OFS_DMA_CFG, HCR_DMA_CFG_RST);
        foreach (pats[i]) begin
            apb(1'b1, HCR_OFS_SCRATCH, pats[i]);
            rdc(HCR_OFS_SCRATCH, pats[i]);
        end
        pstrb <= 4'h2;
        apb(1'b1, HCR_OFS_SCRATCH, 32'h0);
        pstrb <= 4'hF;
        rdc(HCR_OFS_SCRATCH, 32'hA5C3_005A);
        $display("test regs done");
    endtask
    task automatic t_swreset();
        apb(1'b1, HCR_OFS_SCRATCH, 32'h1234_5678);
        apb(1'b1, HCR_OFS_MODE, 32'h0);
        apb(1'b1, HCR_OFS_DMA_CFG, 32'h0000_2A0C);
        apb(1'b1, HCR_OFS_SWRST, 32'h0);
        seen = 1'b0;
        repeat (8) begin
            @(negedge pclk);
            seen = seen | controller_only_reset | full_reset;
        end
        check({31'h0, seen}, 32'h0);
        apb(1'b1, HCR_OFS_SWRST, 32'h2);
        for (n = 0; n < 8 && controller_only_reset !== 1'b1; n++) @(negedge pclk);
        check({30'h0, controller_only_reset, full_reset}, 32'h2);
        repeat (8) @(negedge pclk);
        rdc(HCR_OFS_SCRATCH, 32'h1234_5678);
        check({31'h0, bus_width_32}, 32'h0);
        apb(1'b1, HCR_OFS_SWRST, 32'h1);
        for (n = 0; n < 8 && full_reset !== 1'b1; n++) @(negedge pclk);
        check({31'h0, full_reset}, 32'h1);
        repeat (8) @(negedge pclk);
        rdc(HCR_OFS_SCRATCH, 32'h0);
        rdc(HCR_OFS_MODE, 32'h0000_0100);
        rdc(HCR_OFS_DMA_CFG, 32'h0);
        rdc(HCR_OFS_SWRST, 32'h0);
        $display("test swreset done");
    endtask
    task automatic t_dma_burst();
        logic [23:0] len;
        int wb, bb, nb;
        for (int k = 0; k < 4; k++) begin
            len = 24'd37 + 24'(k * 50);
            wb = k[0] ? 4 : 2;
            bb = (k == 0) ? 1 : (4 << (k - 1));
            nb = (int'(len) + wb - 1) / wb;
            gap <= 4'(k);
            apb(1'b1, HCR_OFS_MODE, k[0] ? 32'h100 : 32'h0);
            beats = 0;
            dones = 0;
            apb(1'b1, HCR_OFS_DMA_CFG, {len, 4'h0, 2'(k), 1'b1, k[1]});
            for (n = 0; n < 10 && dma_active !== 1'b1; n++) @(negedge pclk);
            check({31'h0, dma_read_dir}, {31'h0, k[1]});
            check({27'h0, dma_burst_beats}, 32'(bb));
            rdc(HCR_OFS_DMA_BURSTS, 32'((nb + bb - 1) / bb));
            for (n = 0; n < 2000 && dones == 0; n++) @(negedge pclk);
            repeat (3) @(negedge pclk);
            check(32'(beats), 32'(nb));
            check({dma_active, 31'(dones)}, 32'h1);
            rdc(HCR_OFS_DMA_CFG, {len, 4'h0, 2'(k), 1'b0, k[1]});
        end
        $display("test dma burst done");
    endtask
    task automatic t_dma_stop();
        apb(1'b1, HCR_OFS_MODE, 32'h100);
        gap <= 4'h3;
        beats = 0;
        dones = 0;
        apb(1'b1, HCR_OFS_DMA_CFG, 32'h0003_E807);
        repeat (20) @(negedge pclk);
        // Hold beats off so none meets the cycle in which the engine stops
        gap <= 4'hF;
        apb(1'b1, HCR_OFS_DMA_CFG, 32'h0003_E805);
        repeat (4) @(negedge pclk);
        check({31'h0, dma_active}, 32'h0);
        rdc(HCR_OFS_DMA_STAT, {24'(1000 - 4 * beats), 8'h00});
        check(32'(dones), 32'h0);
        $display("test dma stop done");
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_ident();
        t_regs();
        t_swreset();
        t_dma_burst();
        t_dma_stop();
        give_verdict();
    end
endmodule
bind hcr_cpu_if_regs hcr_cpu_if_regs_chk #(
    .HW_VERSION(HW_VERSION), .PART_CODE(PART_CODE), .PULSE_CYCLES(PULSE_CYCLES)) chk (.*);

// >>> verif/hcr_dma_peer.sv
// DMA far-side model issuing one beat per transfer at a chosen pace
`timescale 1ns/1ps
module hcr_dma_peer (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       dma_active,
    input  wire logic [3:0] gap,
    // Beat strobe
    output logic            dma_beat
);
    logic [3:0] idle;
    // Beats only while the engine runs, spaced by gap idle cycles, or by one when gap is zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle     <= 4'h0;
            dma_beat <= 1'b0;
        end else if (dma_active && !dma_beat && idle >= gap) begin
            idle     <= 4'h0;
            dma_beat <= 1'b1;
        end else begin
            idle     <= (idle < gap) ? idle + 4'h1 : idle;
            dma_beat <= 1'b0;
        end
    end
endmodule
